// ### src/uc_first_counter.sv
// Top of the eight-bit up counter with shared prescaler, APB register slave.
// Assumes pclk is the instruction clock and the pins are slower than it.
//
// Overview of operation
// - Eight-bit up counter advances only while its enable bit is set.
// - Writing the counter loads a new start count; reading returns the count.
// - Source select and low-clock select choose the count source; zero means instruction clock.
// - Source select one with low-clock zero counts the external clock pin.
// - Source select and low-clock select both one count the low RC oscillator.
// - Edge select picks falling edges when one, rising edges when zero.
// - With assign bit zero the selected clock passes through the prescaler.
// - Writing zero to the assign bit clears the prescaler count.
// - Three-bit rate field divides by two up to 256 in powers of two.
// - The pin and oscillator sources are synchronised to the instruction clock first.
// - Counter overflow sets the overflow flag.
// - Interrupt request needs the flag plus overflow and global enables.
// - Overflow flag stays set until software writes zero to it.
// - Port pin two is the external clock input in pin source mode.
// - Assign bit one hands the prescaler to the watchdog, bypassing it here.
// - Global enable must be one for any hardware interrupt request.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module uc_first_counter
  import uc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count sources
  input wire logic port_pin_two,
  input wire logic internal_low_rc_osc,
  // Interrupt request towards the core
  output logic irq_req
);

  // ----------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    return a == {24'h000000, off};
  endfunction

  wire access = psel & penable;
  wire xfer = access & pready;
  wire wr = xfer & pwrite;
  wire hit_count = addr_hit(paddr, ADDR_COUNT);
  wire hit_mode = addr_hit(paddr, ADDR_MODE);
  wire hit_pwr = addr_hit(paddr, ADDR_PWR);
  wire hit_iflag = addr_hit(paddr, ADDR_IFLAG);
  wire hit_ien = addr_hit(paddr, ADDR_IEN);
  wire hit_pscv = addr_hit(paddr, ADDR_PSCV);
  wire mapped = hit_count | hit_mode | hit_pwr | hit_iflag | hit_ien | hit_pscv;
  wire wr_count = wr & hit_count;
  wire wr_mode = wr & hit_mode;
  wire wr_pwr = wr & hit_pwr;
  wire wr_iflag = wr & hit_iflag;
  wire wr_ien = wr & hit_ien;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] count;
  uc_mode_t mode;
  logic counter_enable_bit;
  logic global_irq_enable;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [7:0] psc_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= uc_mode_t'(MODE_RST);
      counter_enable_bit <= 1'b0;
      global_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode <= uc_mode_t'(pwdata[7:0]);
      end
      if (wr_pwr) begin
        counter_enable_bit <= pwdata[PWR_EN_BIT];
        global_irq_enable <= pwdata[PWR_GIE_BIT];
      end
      if (wr_ien) begin
        overflow_irq_enable <= pwdata[IEN_OVF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source selection and synchronisation
  // ----------------------------------------------------------------------
  logic [NUM_SOURCES-1:0] src_rise;
  logic [NUM_SOURCES-1:0] src_fall;
  uc_src_t src_kind;
  logic src_tick;

  // Pin and oscillator pass two flops before any edge is taken
  uc_sync_edge u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({internal_low_rc_osc, port_pin_two}),
    .rise(src_rise),
    .fall(src_fall)
  );

  assign src_kind = !mode.count_source_select ? SRC_INSN :
                    (mode.low_clock_select ? SRC_LRC : SRC_PIN);

  always_comb begin
    src_tick = 1'b0;
    case (src_kind)
      SRC_INSN: src_tick = 1'b1;
      SRC_PIN: src_tick = mode.count_edge_select ? src_fall[0] : src_rise[0];
      SRC_LRC: src_tick = mode.count_edge_select ? src_fall[1] : src_rise[1];
      default: src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------------
  // Rate r selects the low r+1 bits; all ones marks the last input of a period
  wire [7:0] rate_mask = MASK_FULL >> (RATE_TOP - mode.prescaler_rate_field);
  wire psc_full = (psc_cnt & rate_mask) == rate_mask;
  wire psc_step = counter_enable_bit & src_tick & ~mode.prescaler_assign_bit;
  wire psc_clear = wr_mode & ~pwdata[MODE_ASSIGN_BIT];
  // Watchdog ownership passes every source tick straight to the count
  wire cnt_tick = counter_enable_bit & src_tick &
                  (mode.prescaler_assign_bit | psc_full);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_cnt <= PSC_RST;
    end else if (psc_clear) begin
      psc_cnt <= PSC_RST;
    end else if (psc_step) begin
      psc_cnt <= psc_cnt + COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------------
  // Counter, overflow flag and interrupt
  // ----------------------------------------------------------------------
  // A software load wins over a tick in the same cycle and suppresses overflow
  wire overflow = cnt_tick & ~wr_count & (count == COUNT_MAX);
  wire flag_clear = wr_iflag & ~pwdata[IFLAG_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RST;
    end else if (wr_count) begin
      count <= pwdata[7:0];
    end else if (cnt_tick) begin
      count <= count + COUNT_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (overflow) begin
      overflow_flag <= 1'b1;
    end else if (flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= overflow_flag & overflow_irq_enable & global_irq_enable;
    end
  end

  // ----------------------------------------------------------------------
  // APB answer: one wait state, read data captured before the final edge
  // ----------------------------------------------------------------------
  logic [31:0] read_mux;

  assign read_mux = hit_count ? {24'h000000, count} :
                    hit_mode ? {24'h000000, mode} :
                    hit_pwr ? {24'h000000, global_irq_enable, 6'h00, counter_enable_bit} :
                    hit_iflag ? {31'h00000000, overflow_flag} :
                    hit_ien ? {31'h00000000, overflow_irq_enable} :
                    hit_pscv ? {24'h000000, psc_cnt} :
                    32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        pslverr <= ~mapped;
        prdata <= pwrite ? 32'h00000000 : read_mux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire pin_rise_cfg = counter_enable_bit & (src_kind == SRC_PIN) & ~mode.count_edge_select &
                      mode.prescaler_assign_bit & ~psel;
  wire lrc_fall_cfg = counter_enable_bit & (src_kind == SRC_LRC) & mode.count_edge_select &
                      mode.prescaler_assign_bit & ~psel;
  wire pin_fall_cfg = counter_enable_bit & (src_kind == SRC_PIN) & mode.count_edge_select &
                      mode.prescaler_assign_bit & ~psel;
  wire lrc_rise_cfg = counter_enable_bit & (src_kind == SRC_LRC) & ~mode.count_edge_select &
                      mode.prescaler_assign_bit & ~psel;
  wire pin_quiet_cfg = counter_enable_bit & (src_kind == SRC_PIN) & mode.prescaler_assign_bit & ~psel;
  wire lrc_quiet_cfg = counter_enable_bit & (src_kind == SRC_LRC) & mode.prescaler_assign_bit & ~psel;

  sequence pin_rises;
    (pin_rise_cfg && !port_pin_two) ##1 (pin_rise_cfg && port_pin_two) ##1 pin_rise_cfg;
  endsequence

  sequence lrc_falls;
    (lrc_fall_cfg && internal_low_rc_osc) ##1 (lrc_fall_cfg && !internal_low_rc_osc) ##1 lrc_fall_cfg;
  endsequence

  sequence pin_falls;
    (pin_fall_cfg && port_pin_two) ##1 (pin_fall_cfg && !port_pin_two) ##1 pin_fall_cfg;
  endsequence

  sequence lrc_rises;
    (lrc_rise_cfg && !internal_low_rc_osc) ##1 (lrc_rise_cfg && internal_low_rc_osc) ##1 lrc_rise_cfg;
  endsequence

  // Four quiet samples cover the whole synchroniser delay of an earlier change
  sequence pin_quiet;
    (pin_quiet_cfg && $stable(port_pin_two)) [*4];
  endsequence

  sequence lrc_quiet;
    (lrc_quiet_cfg && $stable(internal_low_rc_osc)) [*4];
  endsequence

  // Prescaler steps since the counter last advanced, kept apart from psc_cnt
  logic [8:0] steps_seen;
  wire [8:0] ratio_less_one = (9'h002 << mode.prescaler_rate_field) - 9'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steps_seen <= 9'h000;
    end else if (psc_clear | cnt_tick) begin
      steps_seen <= 9'h000;
    end else if (psc_step) begin
      steps_seen <= steps_seen + 9'h001;
    end
  end

  a_write_loads_count: assert property (wr_count |=> count == $past(pwdata[7:0]))
    else $error("counter write not loaded");

  a_hold_when_off: assert property (!counter_enable_bit && !wr_count |=> $stable(count))
    else $error("counter moved while disabled");

  a_insn_counts_each: assert property ((src_kind == SRC_INSN) && counter_enable_bit &&
      mode.prescaler_assign_bit && !wr_count |=> count == 8'($past(count) + COUNT_STEP))
    else $error("instruction clock did not advance counter");

  a_pin_rise_counts: assert property (pin_rises |-> ##2 count == 8'($past(count, 3) + COUNT_STEP))
    else $error("pin rising edge not counted two cycles later");

  a_lrc_fall_counts: assert property (lrc_falls |-> ##2 count == 8'($past(count, 3) + COUNT_STEP))
    else $error("oscillator falling edge not counted");

  a_ovf_sets_flag: assert property (overflow |=> overflow_flag && count == COUNT_RST)
    else $error("overflow did not set flag and wrap");

  a_flag_sticky: assert property (overflow_flag && !flag_clear |=> overflow_flag)
    else $error("overflow flag dropped without a zero write");

  a_irq_needs_enables: assert property (irq_req |-> $past(global_irq_enable) &&
      $past(overflow_irq_enable) && $past(overflow_flag))
    else $error("interrupt raised without flag and enables");

  a_psc_clear_write: assert property (psc_clear |=> psc_cnt == PSC_RST)
    else $error("prescaler not cleared on assign write");

  a_psc_gates_tick: assert property (cnt_tick && !mode.prescaler_assign_bit && !wr_mode |=>
      (psc_cnt & rate_mask) == 8'h00)
    else $error("counter ticked before prescaler period ended");

  a_wdt_owns_psc: assert property (mode.prescaler_assign_bit && !wr_mode |=> $stable(psc_cnt))
    else $error("prescaler moved while given to watchdog");

  a_pin_fall_counts: assert property (pin_falls |-> ##2 count == 8'($past(count, 3) + COUNT_STEP))
    else $error("pin falling edge not counted");

  a_lrc_rise_counts: assert property (lrc_rises |-> ##2 count == 8'($past(count, 3) + COUNT_STEP))
    else $error("oscillator rising edge not counted");

  a_pin_quiet_holds: assert property (pin_quiet |=> $stable(count))
    else $error("counter moved with a quiet pin");

  a_lrc_quiet_holds: assert property (lrc_quiet |=> $stable(count))
    else $error("counter moved with a quiet oscillator");

  a_psc_period: assert property (cnt_tick && !mode.prescaler_assign_bit |-> steps_seen == ratio_less_one)
    else $error("prescaler period does not match the rate field");

  a_read_count: assert property (access && !pready && !pwrite && hit_count |=>
      prdata == {24'h000000, $past(count)})
    else $error("count read returned a wrong value");

  a_load_no_ovf: assert property (wr_count && !overflow_flag |=> !overflow_flag)
    else $error("software load raised the overflow flag");

  a_psc_held_off: assert property (!counter_enable_bit && !psc_clear |=> $stable(psc_cnt))
    else $error("prescaler moved while counter disabled");

  a_flag_clear_works: assert property (flag_clear && !overflow |=> !overflow_flag)
    else $error("zero write did not clear overflow flag");

  a_irq_drops: assert property (!overflow_irq_enable |=> !irq_req)
    else $error("interrupt raised with overflow enable off");

  a_gie_gates_irq: assert property (!global_irq_enable |=> !irq_req)
    else $error("interrupt raised with global enable off");

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_unmapped: assert property (access && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

endmodule // uc_first_counter

// ### src/uc_pkg.sv
// Constants, field layouts and types of the up counter with prescaler.
// Assumes a single 20 MHz clock that also serves as the instruction clock.
package uc_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses on the APB
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_PWR = 8'h08;
  localparam logic [7:0] ADDR_IFLAG = 8'h0C;
  localparam logic [7:0] ADDR_IEN = 8'h10;
  localparam logic [7:0] ADDR_PSCV = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int PWR_EN_BIT = 0;
  localparam int PWR_GIE_BIT = 7;
  localparam int IFLAG_OVF_BIT = 0;
  localparam int IEN_OVF_BIT = 0;
  localparam int MODE_ASSIGN_BIT = 3;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [2:0] RATE_TOP = 3'h7;

  // ----------------------------------------------------------------------
  // Timing: cycles of APB wait, synchroniser depth
  // ----------------------------------------------------------------------
  localparam int APB_WAIT_CYCLES = 1;
  localparam int SYNC_STAGES = 2;
  localparam int NUM_SOURCES = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic low_clock_select;
    logic reserved6;
    logic count_source_select;
    logic count_edge_select;
    logic prescaler_assign_bit;
    logic [2:0] prescaler_rate_field;
  } uc_mode_t;

  typedef enum logic [2:0] {
    SRC_INSN = 3'b001,
    SRC_PIN = 3'b010,
    SRC_LRC = 3'b100
  } uc_src_t;

endpackage

// ### src/uc_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of slow inputs.
// Assumes inputs change no faster than the instruction clock.
`timescale 1ns/1ps
module uc_sync_edge
  import uc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw inputs and detected edges
  input wire logic [NUM_SOURCES-1:0] raw,
  output logic [NUM_SOURCES-1:0] rise,
  output logic [NUM_SOURCES-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < NUM_SOURCES; i = i + 1) begin : g_src
      logic s1;
      logic s2;
      logic s3;
      // First stage is read only by the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= raw[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign rise[i] = s2 & ~s3;
      assign fall[i] = ~s2 & s3;
    end
  endgenerate

endmodule // uc_sync_edge

// ### dv/uc_src_model.sv
// Far-side model: drives the count clock pin and the low RC oscillator.
// Assumes pclk is the instruction clock of the block under test.
`timescale 1ns/1ps
module uc_src_model (
  // Clock
  input wire logic pclk,
  // Source levels
  output logic port_pin_two,
  output logic internal_low_rc_osc
);
  initial begin
    port_pin_two = 1'b0;
    internal_low_rc_osc = 1'b0;
  end

  // Each level holds four cycles, so no edge outruns the synchroniser
  task automatic run(input int np, input int no);
    for (int i = 0; i < 5; i++) begin
      repeat (4) @(posedge pclk);
      if (i < np) port_pin_two <= ~port_pin_two;
      if (i < no) internal_low_rc_osc <= ~internal_low_rc_osc;
    end
  endtask
endmodule // uc_src_model

// ### dv/up_counter_with_prescaler_tb.sv
// Self-checking bench for the up counter: APB master and scenario tasks.
// Assumes uc_src_model stands for the two external count sources.
`timescale 1ns/1ps
module up_counter_with_prescaler_tb;
  import uc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, pin, osc;
  logic [31:0] paddr, pwdata, prdata;
  int fails = 0;
  int tests_run = 0;

  uc_first_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pin_two(pin), .internal_low_rc_osc(osc), .irq_req(irq_req));
  uc_src_model i_src (.pclk(pclk), .port_pin_two(pin), .internal_low_rc_osc(osc));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Ends one edge after completion so the next setup never shares a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 16) begin
        fails++;
        close_out();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h000000, d}, rd, err);
    check("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic err;
    apb(1'b0, a, 32'h0, d, err);
    check(what, exp, d);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_reset();
    rdc(ADDR_COUNT, {24'h0, COUNT_RST}, "count");
    rdc(ADDR_MODE, {24'h0, MODE_RST}, "mode");
    rdc(ADDR_PWR, 32'h0, "power");
    rdc(ADDR_IFLAG, 32'h0, "flag");
    rdc(ADDR_IEN, 32'h0, "irq enable");
    rdc(ADDR_PSCV, {24'h0, PSC_RST}, "prescaler");
  endtask

  task automatic sc_unmapped();
    logic [31:0] d;
    logic err;
    wr(ADDR_COUNT, 8'h5A);
    apb(1'b1, 8'h18, 32'h000000A5, d, err);
    check("slave error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h18, 32'h0, d, err);
    check("unmapped data", 32'h0, d);
    rdc(ADDR_COUNT, 32'h5A, "held count");
  endtask

  // Enable and disable writes back to back give exactly four counting cycles
  task automatic sc_overflow();
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_COUNT, 8'hFD);
    wr(ADDR_PWR, 8'h01);
    wr(ADDR_PWR, 8'h00);
    rdc(ADDR_COUNT, 32'h01, "wrapped count");
    rdc(ADDR_IFLAG, 32'h1, "flag set");
    rdc(ADDR_IFLAG, 32'h1, "flag held");
  endtask

  task automatic sc_irq();
    wr(ADDR_IEN, 8'h01);
    repeat (2) @(posedge pclk);
    check("irq without global", 32'h0, {31'h0, irq_req});
    wr(ADDR_PWR, 8'h80);
    repeat (2) @(posedge pclk);
    check("irq", 32'h1, {31'h0, irq_req});
    wr(ADDR_IEN, 8'h00);
    repeat (2) @(posedge pclk);
    check("irq masked", 32'h0, {31'h0, irq_req});
    wr(ADDR_IFLAG, 8'h00);
    rdc(ADDR_IFLAG, 32'h0, "flag cleared");
    wr(ADDR_PWR, 8'h00);
  endtask

  // Five toggles give three edges of the selected kind, the idle source four
  task automatic sc_sources();
    logic [7:0] modes[4] = '{8'h28, 8'h38, 8'hA8, 8'hB8};
    int np[4] = '{5, 5, 4, 4};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE, modes[i]);
      rdc(ADDR_MODE, {24'h0, modes[i]}, "mode");
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_PWR, 8'h01);
      i_src.run(np[i], 9 - np[i]);
      repeat (4) @(posedge pclk);
      wr(ADDR_PWR, 8'h00);
      rdc(ADDR_COUNT, 32'h3, "edge count");
    end
  endtask

  task automatic sc_prescale();
    int ratio;
    int ticks;
    for (int r = 0; r < 8; r++) begin
      ratio = 2 << r;
      ticks = (ratio < 4) ? 4 : ratio;
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_MODE, {5'b00000, 3'(r)});
      wr(ADDR_PWR, 8'h01);
      repeat (ticks - 4) @(posedge pclk);
      wr(ADDR_PWR, 8'h00);
      rdc(ADDR_COUNT, 32'(ticks / ratio), "divided count");
      rdc(ADDR_PSCV, 32'(ticks % 256), "prescaler count");
    end
    // Low oscillator through a 1:4 prescaler: five rising edges give one tick
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_MODE, 8'hA1);
    wr(ADDR_PWR, 8'h01);
    i_src.run(0, 5);
    i_src.run(0, 5);
    repeat (4) @(posedge pclk);
    wr(ADDR_PWR, 8'h00);
    rdc(ADDR_COUNT, 32'h1, "slow prescaled count");
    rdc(ADDR_PSCV, 32'h5, "slow prescaler count");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_unmapped();
    sc_overflow();
    sc_irq();
    sc_sources();
    sc_prescale();
    close_out();
  end
endmodule // up_counter_with_prescaler_tb
